// File: core/position_trigger_unit.sv
// accepts position triggers on a rising edge and latches the chosen command index
module position_trigger_unit
  import servo_input_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  trigger_if.unit trg
);

  logic trig_prev_q, trig_prev_d;
  logic start_q, start_d;
  logic [2:0] index_q, index_d;
  trig_state_t state_q, state_d;
  logic rise;

  assign rise = trg.trigger & ~trig_prev_q;

  always_comb begin
    trig_prev_d = trg.trigger;
    start_d = 1'b0;
    index_d = index_q;
    state_d = state_q;
    case (state_q)
      TRG_IDLE: begin
        // act on the rising edge only while the motor stands still
        if (trg.enable && rise && trg.zero_speed) begin
          start_d = 1'b1;
          index_d = trg.select;
          state_d = TRG_MOVING;
        end
      end
      TRG_MOVING: begin
        // motion ends once zero speed is seen again without a new edge
        if (!trg.enable || (trg.zero_speed && !start_q)) begin
          state_d = TRG_IDLE;
        end
        if (trg.enable && rise && trg.zero_speed) begin
          start_d = 1'b1;
          index_d = trg.select;
          state_d = TRG_MOVING;
        end
      end
      default: begin
        state_d = TRG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev_q <= 1'b0;
      start_q <= 1'b0;
      index_q <= 3'h0;
      state_q <= TRG_IDLE;
    end else begin
      trig_prev_q <= trig_prev_d;
      start_q <= start_d;
      index_q <= index_d;
      state_q <= state_d;
    end
  end

  assign trg.start = start_q;
  assign trg.index = index_q;
  assign trg.moving = (state_q == TRG_MOVING);

endmodule : position_trigger_unit

// File: core/servo_input_defs.svh
// register offsets, field positions and reset values of the input function decoder
`ifndef SERVO_INPUT_DEFS_SVH
`define SERVO_INPUT_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the address port)
// ----------------------------------------------------------------
`define OFS_CONTROL_MODE 8'h00
`define OFS_GEAR_SOURCE 8'h01
`define OFS_SPEED_SOURCE 8'h02
`define OFS_JOG_SPEED 8'h03
`define OFS_INT_POS_MODE 8'h04
`define OFS_NUMERATOR_BASE 8'h08
`define OFS_POS_CMD_BASE 8'h10
`define OFS_STATUS 8'h20

// ----------------------------------------------------------------
// parameter values that select behaviour
// ----------------------------------------------------------------
`define MODE_PARAM_SPEED 8'h01
`define MODE_PARAM_TORQUE 8'h02
`define MODE_PARAM_POS_SPD 8'h03
`define MODE_PARAM_POS_TRQ 8'h04
`define MODE_PARAM_SPD_TRQ 8'h05
`define GEAR_SOURCE_TERMINAL 8'h00
`define SPEED_SOURCE_JOG 8'h05
`define INT_POS_MODE_OFF 8'h00
`define INT_POS_MODE_HOLD 8'h03

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define ST_MODE_LSB 0
`define ST_GEAR_LSB 2
`define ST_POS_LSB 4
`define ST_JOG_RUN 7
`define ST_JOG_CW 8
`define ST_HOLD 9
`define ST_INT_POS 10
`define ST_INHIBIT 11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PARAM 8'h00
`define RST_JOG_SPEED 16'h0064
`define RST_NUMERATOR 16'h0001
`define RST_POS_CMD 32'h0000_0000

`endif

// File: core/servo_input_function_decoder.sv
// digital input function decoder: mode, gear, clear, inhibit, jog, internal position, homing
`include "servo_input_defs.svh"

// How it works
// - Mode parameter 3, 4 or 5 gives a mixed mode chosen by mode select.
// - Parameter 3: select off is position control, on is speed control.
// - Parameter 4: select off is position control, on is torque control.
// - Parameter 5: select off is speed control, on is torque control.
// - Gear source 0: the two gear inputs pick numerator one to four.
// - In position mode the clear input clears the deviation counter.
// - In position mode command pulses pass unless inhibit is on.
// - Speed mode, speed source 5: ccw jog runs ccw at jog speed.
// - Speed mode, speed source 5: cw jog runs cw at jog speed.
// - Both jog inputs on together give no jog motion.
// - Hold stops the motor in internal position mode only with internal position mode parameter 3.
// - A trigger starts motion to the currently selected internal position command.
// - A further trigger is taken only while zero speed is 1.
// - Three select bits, bit 2 highest, index one of eight commands.
// - Home search start begins origin search in internal position mode.
// - Mode parameter 1 is speed control, 2 is torque control.
module servo_input_function_decoder
  import servo_input_pkg::*;
#(
  parameter int NUM_W = 16,
  parameter int SPEED_W = 16,
  parameter int POS_W = 32,
  parameter int POS_CMDS = 8
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // input terminals
  input wire logic MODE_SELECT_INPUT_I,
  input wire logic GEAR_SELECT_LOW_I,
  input wire logic GEAR_SELECT_HIGH_I,
  input wire logic DEVIATION_CLEAR_INPUT_I,
  input wire logic PULSE_INHIBIT_INPUT_I,
  input wire logic JOG_CCW_INPUT_I,
  input wire logic JOG_CW_INPUT_I,
  input wire logic HOLD_INPUT_I,
  input wire logic POSITION_TRIGGER_INPUT_I,
  input wire logic POSITION_SELECT_BIT0_I,
  input wire logic POSITION_SELECT_BIT1_I,
  input wire logic POSITION_SELECT_BIT2_I,
  input wire logic HOME_SEARCH_START_I,
  // drive state and command pulse path
  input wire logic ZERO_SPEED_OUTPUT_I,
  input wire logic CMD_PULSE_I,
  // decoded functions
  output ctrl_mode_t ACTIVE_MODE_O,
  output logic [NUM_W-1:0] GEAR_NUMERATOR_O,
  output logic DEVIATION_CLEAR_O,
  output logic CMD_PULSE_O,
  output logic JOG_RUN_O,
  output logic JOG_CW_O,
  output logic [SPEED_W-1:0] JOG_SPEED_O,
  output logic MOTOR_HOLD_O,
  output logic MOTION_START_O,
  output logic [2:0] POSITION_INDEX_O,
  output logic [POS_W-1:0] POSITION_TARGET_O,
  output logic HOME_START_O
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // parameter 0 and values above 5 fall back to position control
  function automatic ctrl_mode_t decode_mode(input logic [7:0] param, input logic sel);
    ctrl_mode_t m;
    m = CTRL_POSITION;
    case (param)
      `MODE_PARAM_SPEED: m = CTRL_SPEED;
      `MODE_PARAM_TORQUE: m = CTRL_TORQUE;
      `MODE_PARAM_POS_SPD: m = sel ? CTRL_SPEED : CTRL_POSITION;
      `MODE_PARAM_POS_TRQ: m = sel ? CTRL_TORQUE : CTRL_POSITION;
      `MODE_PARAM_SPD_TRQ: m = sel ? CTRL_TORQUE : CTRL_SPEED;
      default: m = CTRL_POSITION;
    endcase
    return m;
  endfunction : decode_mode

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : reg_hit

  function automatic logic is_position(input ctrl_mode_t m);
    return m == CTRL_POSITION;
  endfunction : is_position

  // ----------------------------------------------------------------
  // parameter registers
  // ----------------------------------------------------------------
  logic [7:0] mode_param_q, mode_param_d;
  logic [7:0] gear_src_q, gear_src_d;
  logic [7:0] speed_src_q, speed_src_d;
  logic [7:0] int_pos_mode_q, int_pos_mode_d;
  logic [SPEED_W-1:0] jog_speed_q, jog_speed_d;
  logic [NUM_W-1:0] numerator_q [4];
  logic [NUM_W-1:0] numerator_d [4];
  logic [POS_W-1:0] pos_cmd_q [POS_CMDS];
  logic [POS_W-1:0] pos_cmd_d [POS_CMDS];

  always_comb begin
    mode_param_d = mode_param_q;
    gear_src_d = gear_src_q;
    speed_src_d = speed_src_q;
    int_pos_mode_d = int_pos_mode_q;
    jog_speed_d = jog_speed_q;
    if (WR_I) begin
      if (reg_hit(ADDR_I, `OFS_CONTROL_MODE)) mode_param_d = WDATA_I[7:0];
      if (reg_hit(ADDR_I, `OFS_GEAR_SOURCE)) gear_src_d = WDATA_I[7:0];
      if (reg_hit(ADDR_I, `OFS_SPEED_SOURCE)) speed_src_d = WDATA_I[7:0];
      if (reg_hit(ADDR_I, `OFS_INT_POS_MODE)) int_pos_mode_d = WDATA_I[7:0];
      if (reg_hit(ADDR_I, `OFS_JOG_SPEED)) jog_speed_d = WDATA_I[SPEED_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      mode_param_q <= `RST_PARAM;
      gear_src_q <= `RST_PARAM;
      speed_src_q <= `RST_PARAM;
      int_pos_mode_q <= `RST_PARAM;
      jog_speed_q <= `RST_JOG_SPEED;
    end else begin
      mode_param_q <= mode_param_d;
      gear_src_q <= gear_src_d;
      speed_src_q <= speed_src_d;
      int_pos_mode_q <= int_pos_mode_d;
      jog_speed_q <= jog_speed_d;
    end
  end

  // ----------------------------------------------------------------
  // numerator and position command tables
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : gen_num
    always_comb begin
      numerator_d[g] = numerator_q[g];
      if (WR_I && reg_hit(ADDR_I, `OFS_NUMERATOR_BASE + 8'(g))) begin
        numerator_d[g] = WDATA_I[NUM_W-1:0];
      end
    end
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        numerator_q[g] <= `RST_NUMERATOR;
      end else begin
        numerator_q[g] <= numerator_d[g];
      end
    end
  end

  for (genvar p = 0; p < POS_CMDS; p++) begin : gen_pos
    always_comb begin
      pos_cmd_d[p] = pos_cmd_q[p];
      if (WR_I && reg_hit(ADDR_I, `OFS_POS_CMD_BASE + 8'(p))) begin
        pos_cmd_d[p] = WDATA_I[POS_W-1:0];
      end
    end
    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        pos_cmd_q[p] <= `RST_POS_CMD;
      end else begin
        pos_cmd_q[p] <= pos_cmd_d[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // position trigger unit
  // ----------------------------------------------------------------
  trigger_if trg ();

  ctrl_mode_t mode_now;
  logic int_pos_now;

  assign mode_now = decode_mode(mode_param_q, MODE_SELECT_INPUT_I);
  assign int_pos_now = is_position(mode_now) && (int_pos_mode_q != `INT_POS_MODE_OFF);

  assign trg.enable = int_pos_now;
  assign trg.trigger = POSITION_TRIGGER_INPUT_I;
  assign trg.select = {POSITION_SELECT_BIT2_I, POSITION_SELECT_BIT1_I,
                       POSITION_SELECT_BIT0_I};
  assign trg.zero_speed = ZERO_SPEED_OUTPUT_I;

  position_trigger_unit u_trigger (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .trg(trg.unit)
  );

  // ----------------------------------------------------------------
  // decoded function outputs
  // ----------------------------------------------------------------
  ctrl_mode_t mode_q, mode_d;
  logic [1:0] gear_idx_q, gear_idx_d;
  logic [NUM_W-1:0] gear_num_q, gear_num_d;
  logic dev_clear_q, dev_clear_d;
  logic pulse_q, pulse_d;
  logic jog_run_q, jog_run_d;
  logic jog_cw_q, jog_cw_d;
  logic hold_q, hold_d;
  logic int_pos_q, int_pos_d;
  logic home_prev_q, home_prev_d;
  logic home_start_q, home_start_d;
  logic [POS_W-1:0] target_q, target_d;
  logic jog_enable;

  always_comb begin
    mode_d = mode_now;
    int_pos_d = int_pos_now;
    // terminals choose the numerator only with gear source 0
    gear_idx_d = 2'h0;
    if (gear_src_q == `GEAR_SOURCE_TERMINAL) begin
      gear_idx_d = {GEAR_SELECT_HIGH_I, GEAR_SELECT_LOW_I};
    end
    gear_num_d = numerator_q[gear_idx_d];
    dev_clear_d = is_position(mode_now) && DEVIATION_CLEAR_INPUT_I;
    pulse_d = is_position(mode_now) && !PULSE_INHIBIT_INPUT_I && CMD_PULSE_I;
    jog_enable = (mode_now == CTRL_SPEED) && (speed_src_q == `SPEED_SOURCE_JOG);
    jog_run_d = jog_enable && (JOG_CCW_INPUT_I ^ JOG_CW_INPUT_I);
    // direction keeps its last value while no jog runs
    jog_cw_d = jog_cw_q;
    if (jog_run_d) begin
      jog_cw_d = JOG_CW_INPUT_I;
    end
    hold_d = int_pos_now && (int_pos_mode_q == `INT_POS_MODE_HOLD)
             && HOLD_INPUT_I;
    home_prev_d = HOME_SEARCH_START_I;
    home_start_d = int_pos_now && HOME_SEARCH_START_I && !home_prev_q;
    target_d = target_q;
    if (trg.start) begin
      target_d = pos_cmd_q[trg.index];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      mode_q <= CTRL_POSITION;
      gear_idx_q <= 2'h0;
      gear_num_q <= `RST_NUMERATOR;
      dev_clear_q <= 1'b0;
      pulse_q <= 1'b0;
      jog_run_q <= 1'b0;
      jog_cw_q <= 1'b0;
      hold_q <= 1'b0;
      int_pos_q <= 1'b0;
      home_prev_q <= 1'b0;
      home_start_q <= 1'b0;
      target_q <= `RST_POS_CMD;
    end else begin
      mode_q <= mode_d;
      gear_idx_q <= gear_idx_d;
      gear_num_q <= gear_num_d;
      dev_clear_q <= dev_clear_d;
      pulse_q <= pulse_d;
      jog_run_q <= jog_run_d;
      jog_cw_q <= jog_cw_d;
      hold_q <= hold_d;
      int_pos_q <= int_pos_d;
      home_prev_q <= home_prev_d;
      home_start_q <= home_start_d;
      target_q <= target_d;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status;
  logic num_row, pos_row;

  // table rows decode on the upper address bits, the low bits pick the entry
  assign num_row = ADDR_I[7:2] == 6'(`OFS_NUMERATOR_BASE >> 2);
  assign pos_row = ADDR_I[7:3] == 5'(`OFS_POS_CMD_BASE >> 3);

  always_comb begin
    status = 32'h0;
    status[`ST_MODE_LSB +: 2] = mode_q;
    status[`ST_GEAR_LSB +: 2] = gear_idx_q;
    status[`ST_POS_LSB +: 3] = trg.index;
    status[`ST_JOG_RUN] = jog_run_q;
    status[`ST_JOG_CW] = jog_cw_q;
    status[`ST_HOLD] = hold_q;
    status[`ST_INT_POS] = int_pos_q;
    status[`ST_INHIBIT] = PULSE_INHIBIT_INPUT_I;
  end

  always_comb begin
    rdata_d = 32'h0;
    if (RD_I) begin
      case (ADDR_I)
        `OFS_CONTROL_MODE: rdata_d = {24'h0, mode_param_q};
        `OFS_GEAR_SOURCE: rdata_d = {24'h0, gear_src_q};
        `OFS_SPEED_SOURCE: rdata_d = {24'h0, speed_src_q};
        `OFS_INT_POS_MODE: rdata_d = {24'h0, int_pos_mode_q};
        `OFS_JOG_SPEED: rdata_d = 32'(jog_speed_q);
        `OFS_STATUS: rdata_d = status;
        default: begin
          if (num_row) begin
            rdata_d = 32'(numerator_q[ADDR_I[1:0]]);
          end else if (pos_row) begin
            rdata_d = 32'(pos_cmd_q[ADDR_I[2:0]]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RDATA_O = rdata_q;
  assign ACTIVE_MODE_O = mode_q;
  assign GEAR_NUMERATOR_O = gear_num_q;
  assign DEVIATION_CLEAR_O = dev_clear_q;
  assign CMD_PULSE_O = pulse_q;
  assign JOG_RUN_O = jog_run_q;
  assign JOG_CW_O = jog_cw_q;
  assign JOG_SPEED_O = jog_speed_q;
  assign MOTOR_HOLD_O = hold_q;
  assign MOTION_START_O = trg.start;
  assign POSITION_INDEX_O = trg.index;
  assign POSITION_TARGET_O = target_q;
  assign HOME_START_O = home_start_q;

endmodule : servo_input_function_decoder

// File: core/servo_input_pkg.sv
// types shared by the input function decoder
package servo_input_pkg;

  typedef enum logic [1:0] {
    CTRL_POSITION = 2'b00,
    CTRL_SPEED = 2'b01,
    CTRL_TORQUE = 2'b10
  } ctrl_mode_t;

  typedef enum logic [1:0] {
    TRG_IDLE = 2'b00,
    TRG_MOVING = 2'b01
  } trig_state_t;

endpackage : servo_input_pkg

// File: core/trigger_if.sv
// signals between the decoder and its position trigger unit
interface trigger_if;
  logic enable;
  logic trigger;
  logic [2:0] select;
  logic zero_speed;
  logic start;
  logic [2:0] index;
  logic moving;

  modport decoder (output enable, output trigger, output select, output zero_speed,
                   input start, input index, input moving);
  modport unit (input enable, input trigger, input select, input zero_speed,
                output start, output index, output moving);
endinterface : trigger_if

// File: sim/controller_model.sv
// motion controller model: sets the position select, then raises the trigger
module controller_model (
  // clock and request
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] sel_i,
  // terminals towards the drive
  output logic [2:0] sel_o,
  output logic trig_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] step_q;

  initial begin
    sel_o = 3'h0;
    trig_o = 1'b0;
    step_q = 2'h0;
  end

  // select settles one cycle ahead; trigger high two cycles, then low
  always @(posedge clk_i) begin
    if (step_q == 2'h0 && go_i) begin
      sel_o <= sel_i;
      step_q <= 2'h1;
    end else if (step_q != 2'h0) begin
      trig_o <= (step_q != 2'h3);
      step_q <= step_q + 2'h1;
    end
  end
endmodule : controller_model

// File: sim/servo_input_sva.sv
// concurrent checks on the terminal decoding of the input function decoder
module servo_input_sva (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // input terminals
  input wire logic DEVIATION_CLEAR_INPUT_I,
  input wire logic PULSE_INHIBIT_INPUT_I,
  input wire logic CMD_PULSE_I,
  input wire logic JOG_CCW_INPUT_I,
  input wire logic JOG_CW_INPUT_I,
  input wire logic HOLD_INPUT_I,
  input wire logic POSITION_TRIGGER_INPUT_I,
  input wire logic POSITION_SELECT_BIT0_I,
  input wire logic POSITION_SELECT_BIT1_I,
  input wire logic POSITION_SELECT_BIT2_I,
  input wire logic HOME_SEARCH_START_I,
  input wire logic ZERO_SPEED_OUTPUT_I,
  // decoded functions
  input wire logic DEVIATION_CLEAR_O,
  input wire logic CMD_PULSE_O,
  input wire logic JOG_RUN_O,
  input wire logic JOG_CW_O,
  input wire logic MOTOR_HOLD_O,
  input wire logic MOTION_START_O,
  input wire logic [2:0] POSITION_INDEX_O,
  input wire logic HOME_START_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  clear_cause_a: assert property (DEVIATION_CLEAR_O |-> $past(DEVIATION_CLEAR_INPUT_I))
    else $error("deviation clear without clear input");
  pulse_pass_a: assert property (CMD_PULSE_O |-> $past(CMD_PULSE_I) &&
    !$past(PULSE_INHIBIT_INPUT_I)) else $error("command pulse passed while inhibited");
  jog_both_a: assert property ($past(JOG_CCW_INPUT_I) && $past(JOG_CW_INPUT_I) |->
    !JOG_RUN_O) else $error("jog runs with both jog inputs on");
  jog_cause_a: assert property (JOG_RUN_O |->
    $past(JOG_CCW_INPUT_I) != $past(JOG_CW_INPUT_I)) else $error("jog without one jog input");
  jog_dir_a: assert property (JOG_RUN_O |-> JOG_CW_O == $past(JOG_CW_INPUT_I))
    else $error("jog direction wrong");
  hold_cause_a: assert property (MOTOR_HOLD_O |-> $past(HOLD_INPUT_I))
    else $error("hold without hold input");
  start_edge_a: assert property (MOTION_START_O |-> $past(POSITION_TRIGGER_INPUT_I) &&
    !$past(POSITION_TRIGGER_INPUT_I, 2) && $past(ZERO_SPEED_OUTPUT_I))
    else $error("motion start without accepted trigger edge");
  start_once_a: assert property (MOTION_START_O |=> !MOTION_START_O)
    else $error("motion start longer than one cycle");
  start_index_a: assert property (MOTION_START_O |-> POSITION_INDEX_O ==
    {$past(POSITION_SELECT_BIT2_I), $past(POSITION_SELECT_BIT1_I),
    $past(POSITION_SELECT_BIT0_I)}) else $error("latched index differs from select");
  home_edge_a: assert property (HOME_START_O |-> $past(HOME_SEARCH_START_I) &&
    !$past(HOME_SEARCH_START_I, 2) ##1 !HOME_START_O) else $error("home start not an edge pulse");
endmodule : servo_input_sva

bind servo_input_function_decoder servo_input_sva chk (
  .CLK_SYS_I, .RST_I, .DEVIATION_CLEAR_INPUT_I, .PULSE_INHIBIT_INPUT_I, .CMD_PULSE_I,
  .JOG_CCW_INPUT_I, .JOG_CW_INPUT_I, .HOLD_INPUT_I, .POSITION_TRIGGER_INPUT_I,
  .POSITION_SELECT_BIT0_I, .POSITION_SELECT_BIT1_I, .POSITION_SELECT_BIT2_I,
  .HOME_SEARCH_START_I, .ZERO_SPEED_OUTPUT_I, .DEVIATION_CLEAR_O, .CMD_PULSE_O, .JOG_RUN_O,
  .JOG_CW_O, .MOTOR_HOLD_O, .MOTION_START_O, .POSITION_INDEX_O, .HOME_START_O
);

// File: sim/testbench.sv
// self-checking bench of the input function decoder
`include "servo_input_defs.svh"
module testbench import servo_input_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr, rd, msel, glo, ghi, clr, pulse_inhibit_input, jccw, jcw, hold, home, zero_speed_output, pls, go;
  logic trig, dclr, pout, jrun, jdir, mhold, mstart, hstart;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, ptgt, tmp;
  logic [2:0] sel, psel, pidx;
  logic [15:0] gnum, jspd;
  logic [31:0] num [4];
  logic [31:0] pcmd [8];
  ctrl_mode_t amode;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  servo_input_function_decoder dut (
    .CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .MODE_SELECT_INPUT_I(msel), .GEAR_SELECT_LOW_I(glo),
    .GEAR_SELECT_HIGH_I(ghi), .DEVIATION_CLEAR_INPUT_I(clr), .PULSE_INHIBIT_INPUT_I(pulse_inhibit_input),
    .JOG_CCW_INPUT_I(jccw), .JOG_CW_INPUT_I(jcw), .HOLD_INPUT_I(hold),
    .POSITION_TRIGGER_INPUT_I(trig), .POSITION_SELECT_BIT0_I(psel[0]),
    .POSITION_SELECT_BIT1_I(psel[1]), .POSITION_SELECT_BIT2_I(psel[2]),
    .HOME_SEARCH_START_I(home), .ZERO_SPEED_OUTPUT_I(zero_speed_output), .CMD_PULSE_I(pls),
    .ACTIVE_MODE_O(amode), .GEAR_NUMERATOR_O(gnum), .DEVIATION_CLEAR_O(dclr),
    .CMD_PULSE_O(pout), .JOG_RUN_O(jrun), .JOG_CW_O(jdir), .JOG_SPEED_O(jspd),
    .MOTOR_HOLD_O(mhold), .MOTION_START_O(mstart), .POSITION_INDEX_O(pidx),
    .POSITION_TARGET_O(ptgt), .HOME_START_O(hstart)
  );
  controller_model ctl (.clk_i(clk), .go_i(go), .sel_i(sel), .sel_o(psel), .trig_o(trig));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // bus cycles, comparison and expectations
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask : rd_reg

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic trigger(input logic [2:0] s, input logic z);
    bit seen = 1'b0;
    @(posedge clk);
    zero_speed_output <= z;
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (mstart === 1'b1 && !seen) begin
        seen = 1'b1;
        cmp(32'(pidx), 32'(s));
        @(posedge clk);
        #1;
        cmp(ptgt, pcmd[s]);
      end
    end
    cmp(32'(seen), 32'(z));
  endtask : trigger

  function automatic ctrl_mode_t exp_mode(input int p, input logic c);
    case (p)
      1: return CTRL_SPEED;
      2: return CTRL_TORQUE;
      3: return c ? CTRL_SPEED : CTRL_POSITION;
      4: return c ? CTRL_TORQUE : CTRL_POSITION;
      5: return c ? CTRL_TORQUE : CTRL_SPEED;
      default: return CTRL_POSITION;
    endcase
  endfunction : exp_mode

  task automatic finish_test();
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, wr, rd, msel, glo, ghi, clr, pulse_inhibit_input, jccw, jcw, hold, home, zero_speed_output, pls, go} = 15'h4000;
    addr = 8'h00;
    wdata = 32'h0;
    sel = 3'h0;
    tmp = $urandom(32'hc77f);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp(32'(gnum), 32'h1);
    cmp(32'(jspd), 32'h64);
    rd_reg(`OFS_JOG_SPEED, 32'h64);
    rd_reg(`OFS_NUMERATOR_BASE, 32'h1);
    rd_reg(8'h3f, 32'h0);
    for (int p = 0; p < 7; p++) begin
      wr_reg(`OFS_CONTROL_MODE, 32'(p));
      rd_reg(`OFS_CONTROL_MODE, 32'(p));
      for (int c = 0; c < 2; c++) begin
        @(posedge clk);
        msel <= c[0];
        settle();
        cmp(32'(amode), 32'(exp_mode(p, c[0])));
      end
    end
    wr_reg(`OFS_CONTROL_MODE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      num[i] = 32'(16'($urandom));
      wr_reg(8'(`OFS_NUMERATOR_BASE + i), num[i]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {ghi, glo} <= 2'(i);
      settle();
      cmp(32'(gnum), num[i]);
    end
    wr_reg(`OFS_GEAR_SOURCE, 32'h1);
    settle();
    cmp(32'(gnum), num[0]);
    for (int m = 0; m < 2; m++) begin
      wr_reg(`OFS_CONTROL_MODE, 32'(m));
      @(posedge clk);
      clr <= 1'b1;
      settle();
      cmp(32'(dclr), 32'(m == 0));
      for (int i = 0; i < 2; i++) begin
        @(posedge clk);
        clr <= 1'b0;
        pulse_inhibit_input <= i[0];
        pls <= 1'b1;
        @(posedge clk);
        pls <= 1'b0;
        #1;
        cmp(32'(pout), 32'(m == 0 && i == 0));
      end
    end
    tmp = 32'(16'($urandom));
    wr_reg(`OFS_JOG_SPEED, tmp);
    wr_reg(`OFS_SPEED_SOURCE, {24'h0, `SPEED_SOURCE_JOG});
    for (int j = 1; j < 4; j++) begin
      @(posedge clk);
      {jcw, jccw} <= 2'(j);
      settle();
      cmp(32'(jrun), 32'(j != 3));
      if (j != 3) cmp(32'(jdir), 32'(j == 2));
    end
    cmp(32'(jspd), tmp);
    wr_reg(`OFS_SPEED_SOURCE, 32'h0);
    @(posedge clk);
    {jcw, jccw} <= 2'h1;
    settle();
    cmp(32'(jrun), 32'h0);
    wr_reg(`OFS_CONTROL_MODE, 32'h0);
    wr_reg(`OFS_INT_POS_MODE, {24'h0, `INT_POS_MODE_HOLD});
    for (int i = 0; i < 8; i++) begin
      pcmd[i] = $urandom;
      wr_reg(8'(`OFS_POS_CMD_BASE + i), pcmd[i]);
    end
    for (int k = 0; k < 8; k++) begin
      trigger(3'(7 - k), 1'b1);
    end
    trigger(3'h2, 1'b0);
    @(posedge clk);
    zero_speed_output <= 1'b1;
    hold <= 1'b1;
    settle();
    cmp(32'(mhold), 32'h1);
    wr_reg(`OFS_INT_POS_MODE, 32'h1);
    settle();
    cmp(32'(mhold), 32'h0);
    for (int h = 0; h < 2; h++) begin
      if (h == 1) wr_reg(`OFS_INT_POS_MODE, 32'h0);
      @(posedge clk);
      home <= 1'b1;
      @(posedge clk);
      #1;
      cmp(32'(hstart), 32'(h == 0));
      @(posedge clk);
      #1;
      cmp(32'(hstart), 32'h0);
      @(posedge clk);
      home <= 1'b0;
    end
    finish_test();
  end
endmodule : testbench
